/* src/gtsr_defines.vh */
// Purpose: constants for the gated timer with start and run flag
// Assumes: byte-addressed register port
// Notes:   register addresses are byte offsets
`ifndef GTSR_DEFINES_VH
`define GTSR_DEFINES_VH

`define GTSR_ADDR_W          8
`define GTSR_DATA_W          32
`define GTSR_CNT_W           16

// register offsets
`define GTSR_OFS_CLKGATE     8'h00
`define GTSR_OFS_CMD         8'h04
`define GTSR_OFS_STATUS      8'h08
`define GTSR_OFS_COUNT       8'h0C

// field positions
`define GTSR_CLKGATE_T0_BIT  0
`define GTSR_CMD_START_BIT   0
`define GTSR_CMD_STOP_BIT    1
`define GTSR_STATUS_RUN_BIT  0
`define GTSR_STATUS_CLK_BIT  1

// reset values
`define GTSR_CLKGATE_RST     32'h0000_0000
`define GTSR_COUNT_RST       16'h0000

`endif

/* src/gtsr_timer.v */
// Purpose: timer unit zero with clock gate, start command, run flag and counter
// Assumes: one clock clk at 125 MHz, sys_rst asynchronous active high
// Notes:   gate enable is a clock-enable term, no gated clock net
//
// Operation
// [R1] after reset every peripheral clock gate is off so the timer gets no clock.
// [R2] the timer is clocked only while its bit in the clock gate register is set.
// [R3] writing one to the start bit of the command register starts counting and is not stored.
// [R4] the run flag reads zero until the timer is started.
// [R5] after the start command the run flag reads one.
// [R6] while running the counter increases and software can read it.
// [R7] a software write to the counter replaces its value and counting goes on from there.
// [R8] the counter adds one per enabled timer clock cycle and holds while gated off.
`timescale 1ns/10ps
`default_nettype none
`include "gtsr_defines.vh"

module gtsr_timer #(
    parameter CNT_W = `GTSR_CNT_W
) (
    // clock and reset
    input  wire                        clk,
    input  wire                        sys_rst,
    // register port
    input  wire [`GTSR_ADDR_W-1:0]     reg_addr,
    input  wire [`GTSR_DATA_W-1:0]     reg_wdata,
    input  wire                        reg_wr,
    input  wire                        reg_rd,
    output reg  [`GTSR_DATA_W-1:0]     reg_rdata,
    // state
    output reg                         timer_running,
    output reg                         timer_clk_on
);

    // run state codes
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    // register state
    reg  [`GTSR_DATA_W-1:0] clkgate_q;
    reg  [`GTSR_DATA_W-1:0] clkgate_d;
    reg                     state_q;
    reg                     state_d;
    reg  [CNT_W-1:0]        count_value_q;
    reg  [CNT_W-1:0]        count_value_d;

    // read path
    reg  [`GTSR_DATA_W-1:0] status_word;
    reg  [`GTSR_DATA_W-1:0] rdata_d;
    reg  [`GTSR_DATA_W-1:0] rdata_out_d;

    // decode
    wire                    sel_clkgate;
    wire                    sel_cmd;
    wire                    sel_status;
    wire                    sel_count;
    wire                    gate_on;
    wire                    run_on;
    wire                    wr_clkgate;
    wire                    wr_cmd;
    wire                    start_cmd;
    wire                    stop_cmd;
    wire                    wr_cnt;
    wire                    cnt_step;

    // address match
    function hit;
        input [`GTSR_ADDR_W-1:0] addr;
        input [`GTSR_ADDR_W-1:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // counter plus one, wraps at all ones
    function [CNT_W-1:0] inc;
        input [CNT_W-1:0] val;
        begin
            inc = val + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // count into a data word, upper bits zero
    function [`GTSR_DATA_W-1:0] widen;
        input [CNT_W-1:0] val;
        begin
            widen            = {`GTSR_DATA_W{1'b0}};
            widen[CNT_W-1:0] = val;
        end
    endfunction

    // address decode
    assign sel_clkgate = hit(reg_addr, `GTSR_OFS_CLKGATE);
    assign sel_cmd     = hit(reg_addr, `GTSR_OFS_CMD);
    assign sel_status  = hit(reg_addr, `GTSR_OFS_STATUS);
    assign sel_count   = hit(reg_addr, `GTSR_OFS_COUNT);

    // strobes, command and count writes ignored while the timer clock is off
    assign wr_clkgate  = reg_wr && sel_clkgate;
    assign wr_cmd      = reg_wr && sel_cmd && gate_on;
    assign start_cmd   = wr_cmd && reg_wdata[`GTSR_CMD_START_BIT]; // R3
    assign stop_cmd    = wr_cmd && reg_wdata[`GTSR_CMD_STOP_BIT];
    assign wr_cnt      = reg_wr && sel_count && gate_on;

    // gate and run state
    assign gate_on     = clkgate_q[`GTSR_CLKGATE_T0_BIT]; // R2
    assign run_on      = (state_q == ST_RUN);
    assign cnt_step    = run_on && gate_on; // R8

    // clock gate register, all bits kept
    always @* begin
        clkgate_d = clkgate_q;
        if (wr_clkgate) begin
            clkgate_d = reg_wdata;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clkgate_q <= `GTSR_CLKGATE_RST; // R1
        end else begin
            clkgate_q <= clkgate_d;
        end
    end

    // run state, start is a trigger only and wins over stop
    always @* begin
        case (state_q)
            ST_IDLE: begin
                if (start_cmd) begin
                    state_d = ST_RUN; // R3 R5
                end else begin
                    state_d = ST_IDLE; // R4
                end
            end
            ST_RUN: begin
                if (stop_cmd && !start_cmd) begin
                    state_d = ST_IDLE;
                end else begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE; // R4
        end else begin
            state_q <= state_d;
        end
    end

    // counter next value, write wins over step
    always @* begin
        count_value_d = count_value_q;
        if (wr_cnt) begin
            count_value_d = reg_wdata[CNT_W-1:0]; // R7
        end else if (cnt_step) begin
            count_value_d = inc(count_value_q); // R6 R8
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_value_q <= `GTSR_COUNT_RST;
        end else begin
            count_value_q <= count_value_d;
        end
    end

    // status word
    always @* begin
        status_word                       = {`GTSR_DATA_W{1'b0}};
        status_word[`GTSR_STATUS_RUN_BIT] = run_on; // R4 R5
        status_word[`GTSR_STATUS_CLK_BIT] = gate_on;
    end

    // read mux, gated-off timer reads zero
    always @* begin
        rdata_d = {`GTSR_DATA_W{1'b0}};
        if (sel_clkgate) begin
            rdata_d = clkgate_q;
        end else if (sel_status && gate_on) begin
            rdata_d = status_word; // R4 R5
        end else if (sel_count && gate_on) begin
            rdata_d = widen(count_value_q); // R6
        end
    end

    // read data stands one cycle only
    always @* begin
        rdata_out_d = {`GTSR_DATA_W{1'b0}};
        if (reg_rd) begin
            rdata_out_d = rdata_d;
        end
    end

    // output flops
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= {`GTSR_DATA_W{1'b0}};
        end else begin
            reg_rdata <= rdata_out_d;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_running <= 1'b0;
        end else begin
            timer_running <= run_on;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_clk_on <= 1'b0; // R1
        end else begin
            timer_clk_on <= gate_on;
        end
    end

endmodule
`default_nettype wire

/* dv/gtsr_timer_asserts.sv */
// Purpose: port checks for gtsr_timer
// Assumes: clk 125 MHz, sys_rst async high
// Notes:   bound to the top module
`timescale 1ns/10ps
`default_nettype none
module gtsr_timer_asserts (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // state
    input wire logic        timer_running,
    input wire logic        timer_clk_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic       rd_q;
    logic [7:0] ad_q;
    always_ff @(posedge clk) begin
        rd_q <= reg_rd;
        ad_q <= reg_addr;
    end
    property p_rst; $fell(sys_rst) |-> !timer_clk_on && !timer_running; endproperty
    a_rst: assert property (p_rst) else $error("active after reset");
    property p_ron; $rose(timer_clk_on) |-> $past(reg_wr && reg_addr == 8'h00 && reg_wdata[0], 2); endproperty
    a_ron: assert property (p_ron) else $error("clock on unasked");
    property p_gof; rd_q && ad_q[7:3] == 5'h01 && !timer_clk_on |-> reg_rdata == 0; endproperty
    a_gof: assert property (p_gof) else $error("gated read not zero");
    property p_st; rd_q && ad_q == 8'h08 && timer_clk_on |-> reg_rdata == {30'h0, 1'b1, timer_running}; endproperty
    a_st: assert property (p_st) else $error("status mismatch");
    property p_cmd; rd_q && ad_q == 8'h04 |-> reg_rdata == 0; endproperty
    a_cmd: assert property (p_cmd) else $error("command stored");
    property p_hi; rd_q && ad_q == 8'h0C |-> reg_rdata[31:16] == 0; endproperty
    a_hi: assert property (p_hi) else $error("count upper bits");
    property p_idl; !rd_q |-> reg_rdata == 0; endproperty
    a_idl: assert property (p_idl) else $error("read data outside slot");
    property p_go; $rose(timer_running) |-> $past(reg_wr && reg_addr == 8'h04 && reg_wdata[0], 2); endproperty
    a_go: assert property (p_go) else $error("run without start");
    c_go: cover property ($rose(timer_running));
    c_cnt: cover property (rd_q && ad_q == 8'h0C && reg_rdata != 0);
    c_off: cover property ($fell(timer_clk_on));
    c_stop: cover property ($fell(timer_running));
endmodule
bind gtsr_timer gtsr_timer_asserts gtsr_timer_asserts_i (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .timer_running (timer_running),
    .timer_clk_on  (timer_clk_on)
);
`default_nettype wire

/* dv/gtsr_timer_tb.sv */
// Purpose: register tests of gtsr_timer
// Assumes: 8 ns clock, 12-cycle reset
// Notes:   count checks use read spacing
`timescale 1ns/10ps
`default_nettype none
module gtsr_timer_tb;
    logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, timer_running, timer_clk_on;
    logic [7:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, v, w;
    int          mismatches = 0, compares = 0;
    always #4 clk = ~clk;
    gtsr_timer gtsr_timer_i (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .timer_running (timer_running),
        .timer_clk_on  (timer_clk_on)
    );
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        @(negedge clk);
        v = reg_rdata;
    endtask
    task automatic chk(input logic c);
        compares++;
        if (c !== 1'b1) begin
            mismatches++;
            $display("mismatch %0t read %h", $time, v);
        end
    endtask
    task automatic final_report;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 0;
        rd(8'h08); chk(v === 0);
        wr(8'h0C, 5); wr(8'h00, 1); rd(8'h0C); chk(v === 0);
        rd(8'h08); chk(v === 2 && timer_clk_on === 1'b1);
        wr(8'h0C, 16); rd(8'h0C); chk(v === 16);
        wr(8'h04, 1); rd(8'h08); chk(v === 3 && timer_running === 1'b1);
        rd(8'h04); chk(v === 0);
        rd(8'h0C); w = v; rd(8'h0C); chk(w > 16 && v - w === 2);
        w = v; wr(8'h00, 0); rd(8'h0C); chk(v === 0);
        repeat (20) @(posedge clk);
        wr(8'h00, 1); rd(8'h0C); chk(v - w === 4);
        wr(8'h04, 0); rd(8'h08); chk(v === 3);
        wr(8'h04, 2); rd(8'h08); chk(v === 2);
        rd(8'h0C); w = v; rd(8'h0C); chk(v === w && timer_running === 1'b0);
        wr(8'h04, 3); rd(8'h08); chk(v === 3 && timer_running === 1'b1);
        @(posedge clk);
        sys_rst <= 1;
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        chk(timer_clk_on === 1'b0 && timer_running === 1'b0);
        wr(8'h00, 1); rd(8'h0C); chk(v === 0 && timer_clk_on === 1'b1);
        final_report;
    end
    initial begin
        #20000;
        mismatches++;
        final_report;
    end
endmodule
`default_nettype wire
